// File: shared/sil_pkg.sv
// Purpose: shared constants of the supervisor interrupt logic
// Assumes: 250 MHz system clock, byte-wide register port
// Notes:   source index i maps to flag bit and enable bit 7-i
package sil_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SRC_N  = 3;

    // source indices
    localparam int SRC_WD = 0;
    localparam int SRC_AL = 1;
    localparam int SRC_PF = 2;

    // register addresses
    localparam logic [ADDR_W-1:0] FLAG_ADDR = 15'h7ff0;
    localparam logic [ADDR_W-1:0] CTL_ADDR  = 15'h7ff6;

    // flag register layout
    localparam int FLAG_TOP_BIT = 7;

    // control register layout
    localparam int EN_TOP_BIT = 7;
    localparam int ABE_BIT    = 4;
    localparam int HL_BIT     = 3;
    localparam int PL_BIT     = 2;

    localparam logic [DATA_W-1:0] CTL_RESET = 8'h24;
    localparam logic [DATA_W-1:0] CTL_WMASK = 8'hfc;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_US       = 1000;
    localparam int TICK_CYCLES   = TICK_US * 1000000 / CLK_PERIOD_PS;
    localparam int PULSE_MS      = 200;
    localparam int PULSE_TICKS   = PULSE_MS * 1000 / TICK_US;

    // register port cycle state
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_CYC  = 1'b1
    } sil_bus_e;

endpackage

// File: verilog/sil_tick_div.sv
// Purpose: timebase divider, one-cycle tick every DIV cycles
// Assumes: single clock domain
// Notes:   free running from reset
`timescale 1ns/1ps
module sil_tick_div #(
    parameter int DIV = sil_pkg::TICK_CYCLES
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    output logic      tick_o
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          tick_ff;
    logic          nxt_tick;

    always_comb begin
        nxt_tick = (cnt_ff == LAST);
        nxt_cnt  = nxt_tick ? '0 : cnt_ff + 1'b1;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;
endmodule

// File: verilog/sil_pulse_timer.sv
// Purpose: one-shot of TICKS timebase ticks
// Assumes: tick_i is a one-cycle enable
// Notes:   start restarts and wins over stop
`timescale 1ns/1ps
module sil_pulse_timer #(
    parameter int TICKS = sil_pkg::PULSE_TICKS
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic tick_i,
    input  wire logic start_i,
    input  wire logic stop_i,
    output logic      busy_o
);
    localparam int CW = $clog2(TICKS + 1);
    localparam logic [CW-1:0] LOAD = CW'(TICKS);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (start_i) begin
            nxt_cnt = LOAD;
        end else if (stop_i) begin
            nxt_cnt = '0;
        end else if (tick_i && cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign busy_o = (cnt_ff != '0);
endmodule

// File: verilog/sil_supervisor_irq.sv
// Purpose: supervisor flags, interrupt control register and pin driver
// Assumes: port pins synchronous to clock_i; event inputs are pulses
// Notes:   only the flag and control registers are decoded here
`timescale 1ns/1ps

// Summary of operation
// - three sources: watchdog, power-fail, alarm, each separately enabled
// - source drives pin when event, enable and its backup/lockout gate all high; sources ORed
// - each source sets its flag; reading flag register clears all flags
// - flags clear only after a full read cycle with write strobe high
// - pin driver mode sits in control register bits 3 and 2
// - watchdog enable high drives pin; low only sets flag
// - alarm enable high drives pin; low only sets flag
// - power-fail enable high drives pin; low only sets flag
// - alarm backup enable lets alarm drive pin on backup power
// - backup enable affects alarm only; watchdog never drives on backup
// - enabled power-fail drives pin regardless of alarm backup enable
// - polarity high: active-high push-pull, high only above lockout
// - polarity low: active-low open drain, works on backup power
// - pulse mode: event drives pin for about 200 ms
// - level mode: pin held active until flag register read
// - level mode: flag read clears condition, pin goes inactive
// - pulse mode: flag read clears flags and ends pulse at once
// - battery-less power-on loads control register with 24h
// - watchdog flag is bit 7 of flag register
// - alarm flag is bit 6 of flag register, set on match
// - power-fail flag is bit 5, set when supply drops below threshold
module sil_supervisor_irq #(
    parameter int TICK_CYCLES = sil_pkg::TICK_CYCLES,
    parameter int PULSE_TICKS = sil_pkg::PULSE_TICKS
) (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       ce_n_i,
    input  wire logic                       oe_n_i,
    input  wire logic                       we_n_i,
    input  wire logic [sil_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [sil_pkg::DATA_W-1:0] dq_i,
    output logic      [sil_pkg::DATA_W-1:0] dq_o,
    output logic                            dq_oe_o,
    input  wire logic                       watchdog_timeout_i,
    input  wire logic                       alarm_match_i,
    input  wire logic                       powerfail_i,
    input  wire logic                       vdd_above_lockout_i,
    input  wire logic                       on_backup_i,
    input  wire logic                       load_default_i,
    output logic                            int_o,
    output logic                            int_oe_o
);
    localparam int SN = sil_pkg::SRC_N;
    localparam int DW = sil_pkg::DATA_W;
    localparam int AW = sil_pkg::ADDR_W;

    // register port cycle tracking
    sil_pkg::sil_bus_e  bus_ff;
    sil_pkg::sil_bus_e  nxt_bus;
    logic [AW-1:0]      addr_ff;
    logic [AW-1:0]      nxt_addr;
    logic               rd_ok_ff;
    logic               nxt_rd_ok;
    logic               wr_seen_ff;
    logic               nxt_wr_seen;
    logic [DW-1:0]      wr_data_ff;
    logic [DW-1:0]      nxt_wr_data;
    logic [DW-1:0]      rd_data_ff;
    logic [DW-1:0]      nxt_rd_data;
    logic               flag_clr;
    logic               ctl_wr;

    // control and flag state
    logic [DW-1:0]      ctl_ff;
    logic [DW-1:0]      nxt_ctl;
    logic [SN-1:0]      flag_ff;
    logic [SN-1:0]      nxt_flag;
    logic               pf_prev_ff;
    logic               nxt_pf_prev;

    // per source terms
    logic [SN-1:0]      src_evt;
    logic [SN-1:0]      src_en;
    logic [SN-1:0]      src_gate;
    logic [SN-1:0]      src_new;
    logic [SN-1:0]      src_pend;
    logic [DW-1:0]      flag_word;

    logic               alarm_backup_en;
    logic               pol_high;
    logic               pulse_mode;
    logic               any_new;
    logic               any_pend;
    logic               tick;
    logic               pulse_busy;
    logic               pin_active;

    assign alarm_backup_en = ctl_ff[sil_pkg::ABE_BIT];
    assign pol_high        = ctl_ff[sil_pkg::HL_BIT];
    assign pulse_mode      = ctl_ff[sil_pkg::PL_BIT];

    // power-fail flag sets on the falling supply edge
    assign src_evt[sil_pkg::SRC_WD] = watchdog_timeout_i;
    assign src_evt[sil_pkg::SRC_AL] = alarm_match_i;
    assign src_evt[sil_pkg::SRC_PF] = powerfail_i & ~pf_prev_ff;

    // backup and lockout qualification per source
    assign src_gate[sil_pkg::SRC_WD] = ~on_backup_i;
    assign src_gate[sil_pkg::SRC_AL] = alarm_backup_en |
                                       vdd_above_lockout_i;
    assign src_gate[sil_pkg::SRC_PF] = 1'b1;

    genvar gi;
    generate
        for (gi = 0; gi < SN; gi++) begin : g_src
            assign src_en[gi]   = ctl_ff[sil_pkg::EN_TOP_BIT - gi];
            assign src_new[gi]  = src_evt[gi] & src_en[gi] &
                                  src_gate[gi];
            assign src_pend[gi] = flag_ff[gi] & src_en[gi] &
                                  src_gate[gi];
        end
    endgenerate

    assign any_new  = |src_new;
    assign any_pend = |src_pend;

    always_comb begin
        flag_word = sil_pkg::DATA_ZERO;
        for (int i = 0; i < SN; i++) begin
            flag_word[sil_pkg::FLAG_TOP_BIT - i] = flag_ff[i];
        end
    end

    // register port cycle
    always_comb begin
        nxt_bus     = bus_ff;
        nxt_addr    = addr_ff;
        nxt_rd_ok   = rd_ok_ff;
        nxt_wr_seen = wr_seen_ff;
        nxt_wr_data = wr_data_ff;
        nxt_rd_data = rd_data_ff;
        flag_clr    = 1'b0;
        ctl_wr      = 1'b0;
        case (bus_ff)
            sil_pkg::BUS_IDLE: begin
                if (!ce_n_i) begin
                    nxt_bus     = sil_pkg::BUS_CYC;
                    nxt_addr    = addr_i;
                    nxt_rd_ok   = we_n_i;
                    nxt_wr_seen = ~we_n_i;
                    nxt_wr_data = dq_i;
                    // data ready before the bus may be driven
                    if (addr_i == sil_pkg::FLAG_ADDR) begin
                        nxt_rd_data = flag_word;
                    end else if (addr_i == sil_pkg::CTL_ADDR) begin
                        nxt_rd_data = ctl_ff;
                    end else begin
                        nxt_rd_data = sil_pkg::DATA_ZERO;
                    end
                end
            end
            sil_pkg::BUS_CYC: begin
                if (!we_n_i) begin
                    nxt_rd_ok   = 1'b0;
                    nxt_wr_seen = 1'b1;
                    nxt_wr_data = dq_i;
                end else if (wr_seen_ff) begin
                    ctl_wr      = (addr_ff == sil_pkg::CTL_ADDR);
                    nxt_wr_seen = 1'b0;
                end
                if (ce_n_i) begin
                    nxt_bus = sil_pkg::BUS_IDLE;
                    if (wr_seen_ff && !we_n_i) begin
                        ctl_wr = (addr_ff == sil_pkg::CTL_ADDR);
                    end
                    nxt_wr_seen = 1'b0;
                    flag_clr    = rd_ok_ff & we_n_i &
                                  (addr_ff == sil_pkg::FLAG_ADDR);
                end
                if (addr_ff == sil_pkg::FLAG_ADDR) begin
                    nxt_rd_data = flag_word;
                end else if (addr_ff == sil_pkg::CTL_ADDR) begin
                    nxt_rd_data = ctl_ff;
                end else begin
                    nxt_rd_data = sil_pkg::DATA_ZERO;
                end
            end
            default: begin
                nxt_bus = sil_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_ff     <= sil_pkg::BUS_IDLE;
            addr_ff    <= '0;
            rd_ok_ff   <= 1'b0;
            wr_seen_ff <= 1'b0;
            wr_data_ff <= sil_pkg::DATA_ZERO;
            rd_data_ff <= sil_pkg::DATA_ZERO;
        end else begin
            bus_ff     <= nxt_bus;
            addr_ff    <= nxt_addr;
            rd_ok_ff   <= nxt_rd_ok;
            wr_seen_ff <= nxt_wr_seen;
            wr_data_ff <= nxt_wr_data;
            rd_data_ff <= nxt_rd_data;
        end
    end

    // flags and control register
    always_comb begin
        nxt_pf_prev = powerfail_i;
        nxt_flag    = (flag_ff & ~{SN{flag_clr}}) | src_evt;
        nxt_ctl     = ctl_ff;
        if (load_default_i) begin
            nxt_ctl = sil_pkg::CTL_RESET;
        end else if (ctl_wr) begin
            nxt_ctl = wr_data_ff & sil_pkg::CTL_WMASK;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_ff    <= '0;
            ctl_ff     <= sil_pkg::CTL_RESET;
            pf_prev_ff <= 1'b0;
        end else begin
            flag_ff    <= nxt_flag;
            ctl_ff     <= nxt_ctl;
            pf_prev_ff <= nxt_pf_prev;
        end
    end

    // pulse timebase
    sil_tick_div #(
        .DIV (TICK_CYCLES)
    ) u_tick (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_o  (tick)
    );

    sil_pulse_timer #(
        .TICKS (PULSE_TICKS)
    ) u_pulse (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_i  (tick),
        .start_i (pulse_mode & any_new),
        .stop_i  (flag_clr),
        .busy_o  (pulse_busy)
    );

    // pin driver
    always_comb begin
        if (pulse_mode) begin
            pin_active = pulse_busy;
        end else begin
            pin_active = any_pend;
        end
        if (pol_high) begin
            int_o    = pin_active & vdd_above_lockout_i;
            int_oe_o = vdd_above_lockout_i;
        end else begin
            int_o    = 1'b0;
            int_oe_o = pin_active;
        end
    end

    assign dq_o    = rd_data_ff;
    assign dq_oe_o = (bus_ff == sil_pkg::BUS_CYC) & ~ce_n_i & ~oe_n_i &
                     we_n_i & rd_ok_ff &
                     ((addr_ff == sil_pkg::FLAG_ADDR) |
                      (addr_ff == sil_pkg::CTL_ADDR));
endmodule

// File: bench/sil_host_pin_model.sv
// Purpose: host side of the interrupt pin, resolves the wire level
// Assumes: board pull-up on the pin net
// Notes:   host treats a low wire as reset or interrupt request
`timescale 1ns/1ps
module sil_host_pin_model (
    input  wire logic int_o,
    input  wire logic int_oe_o,
    output logic      pin_o
);
    // released open drain floats up to the pull-up level
    assign pin_o = int_oe_o ? int_o : 1'b1;
endmodule

// File: bench/sil_supervisor_irq_sva.sv
// Purpose: port assertions for sil_supervisor_irq
// Assumes: one clock, async active-low reset
// Notes:   bound at file foot
`timescale 1ns/1ps
module sil_supervisor_irq_sva (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        ce_n_i,
    input wire logic        oe_n_i,
    input wire logic        we_n_i,
    input wire logic [14:0] addr_i,
    input wire logic [7:0]  dq_o,
    input wire logic        dq_oe_o,
    input wire logic        watchdog_timeout_i,
    input wire logic        alarm_match_i,
    input wire logic        powerfail_i,
    input wire logic        vdd_above_lockout_i,
    input wire logic        int_o,
    input wire logic        int_oe_o
);
    logic [14:0] a_ff;
    logic        cyc_ff;
    logic        rd_ff;
    logic        ev;
    assign ev = watchdog_timeout_i | alarm_match_i | powerfail_i;
    // latched address and read status of the open cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a_ff   <= '0;
            cyc_ff <= 1'b0;
            rd_ff  <= 1'b0;
        end else begin
            a_ff   <= (!ce_n_i && !cyc_ff) ? addr_i : a_ff;
            cyc_ff <= !ce_n_i;
            rd_ff  <= !ce_n_i && we_n_i && (rd_ff || !cyc_ff);
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    AST_RST_IDLE: assert property (
        $rose(rst_n_i) |-> !int_oe_o && !dq_oe_o)
        else $error("pin or bus driven after reset");
    AST_WE_NO_DRIVE: assert property (
        !we_n_i |-> !dq_oe_o) else $error("bus driven in write");
    AST_DQ_NEEDS_OE: assert property (
        dq_oe_o |-> !ce_n_i && !oe_n_i) else $error("bus driven unselected");
    AST_HIGH_LOCKOUT: assert property (
        int_o |-> int_oe_o && vdd_above_lockout_i)
        else $error("pin high below lockout");
    AST_MAPPED: assert property (
        dq_oe_o |-> a_ff == sil_pkg::FLAG_ADDR || a_ff == sil_pkg::CTL_ADDR)
        else $error("bus driven for unmapped address");
    AST_CTL_RSVD: assert property (
        dq_oe_o && $past(dq_oe_o) && a_ff == sil_pkg::CTL_ADDR
        |-> dq_o[1:0] == 2'h0) else $error("reserved bits not zero");
    AST_READ_CLEARS: assert property (
        $rose(ce_n_i) && rd_ff && a_ff == sil_pkg::FLAG_ADDR && !ev
        |=> !int_o ##1 (!int_o || $past(ev)))
        else $error("pin high after flag read");
    AST_OE_RELEASE: assert property (
        $rose(ce_n_i) |-> !dq_oe_o) else $error("bus held after cycle");
    COV_FLAG_READ: cover property (
        $rose(ce_n_i) && rd_ff && a_ff == sil_pkg::FLAG_ADDR);
    COV_HIGH: cover property ($rose(int_o));
    COV_LOW: cover property ($rose(int_oe_o) && !int_o);
endmodule

bind sil_supervisor_irq sil_supervisor_irq_sva u_sva (
    .clock_i, .rst_n_i, .ce_n_i, .oe_n_i, .we_n_i, .addr_i, .dq_o,
    .dq_oe_o, .watchdog_timeout_i, .alarm_match_i, .powerfail_i,
    .vdd_above_lockout_i, .int_o, .int_oe_o
);

// File: bench/sil_supervisor_irq_tb_top.sv
// Purpose: self-checking bench for sil_supervisor_irq
// Assumes: short timebase parameters for simulation
// Notes:   reads scored by a monitor from a queue
`timescale 1ns/1ps
module sil_supervisor_irq_tb_top;
    localparam int          TC = 4;
    localparam int          PT = 5;
    localparam logic [14:0] FA = sil_pkg::FLAG_ADDR;
    localparam logic [14:0] CA = sil_pkg::CTL_ADDR;
    logic        clock_i, rst_n_i, ce_n_i, oe_n_i, we_n_i, dq_oe_o;
    logic        watchdog_timeout_i, alarm_match_i, powerfail_i;
    logic        vdd_above_lockout_i, on_backup_i, load_default_i;
    logic        int_o, int_oe_o, pin, was_oe;
    logic [14:0] addr_i;
    logic [7:0]  dq_i, dq_o, last, r;
    logic [7:0]  expq[$];
    int          error_cnt, tests_run, n;

    sil_supervisor_irq #(.TICK_CYCLES(TC), .PULSE_TICKS(PT)) dut (
        .clock_i, .rst_n_i, .ce_n_i, .oe_n_i, .we_n_i, .addr_i, .dq_i,
        .dq_o, .dq_oe_o, .watchdog_timeout_i, .alarm_match_i, .powerfail_i,
        .vdd_above_lockout_i, .on_backup_i, .load_default_i, .int_o,
        .int_oe_o
    );
    sil_host_pin_model u_host (.int_o, .int_oe_o, .pin_o(pin));

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic pinchk(input logic [1:0] e);
        @(negedge clock_i);
        chk("pin", {6'h0, int_oe_o, int_o}, {6'h0, e});
        chk("wire", {7'h0, pin}, {7'h0, e[1] ? e[0] : 1'b1});
        @(posedge clock_i);
    endtask

    // full read cycle, write strobe high throughout
    task automatic rd(input logic [14:0] a, input logic [7:0] e, input bit p);
        if (p) expq.push_back(e);
        ce_n_i <= 1'b0;
        addr_i <= a;
        we_n_i <= 1'b1;
        @(posedge clock_i);
        oe_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        ce_n_i <= 1'b1;
        oe_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        ce_n_i <= 1'b0;
        addr_i <= a;
        we_n_i <= 1'b0;
        dq_i   <= d;
        repeat (2) @(posedge clock_i);
        we_n_i <= 1'b1;
        @(posedge clock_i);
        ce_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic fire(input int s);
        watchdog_timeout_i <= (s == 0);
        alarm_match_i      <= (s == 1);
        powerfail_i        <= (s == 2);
        @(posedge clock_i);
        {watchdog_timeout_i, alarm_match_i, powerfail_i} <= 3'h0;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic gate(input logic b, v, input logic [7:0] c, input int s,
                        input logic [1:0] e);
        on_backup_i         <= b;
        vdd_above_lockout_i <= v;
        wr(CA, c);
        fire(s);
        pinchk(e);
        rd(FA, 8'h80 >> s, 1'b1);
    endtask

    task automatic plen(input int lo, input int hi);
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (int_oe_o && n < 200);
        if (n >= 200) begin
            error_cnt++;
            stop_test();
        end
        chk("len", {7'h0, n >= lo && n <= hi}, 8'h01);
        @(posedge clock_i);
    endtask

    always @(posedge clock_i) begin
        if (dq_oe_o) begin
            last <= dq_o;
        end else if (was_oe) begin
            if (expq.size() > 0) chk("rd", last, expq.pop_front());
            else chk("drive", 8'h01, 8'h00);
        end
        was_oe <= dq_oe_o;
    end

    initial begin
        repeat (30000) @(posedge clock_i);
        error_cnt++;
        stop_test();
    end

    initial begin
        rst_n_i = 1'b0;
        {ce_n_i, oe_n_i, we_n_i} = 3'h7;
        {watchdog_timeout_i, alarm_match_i, powerfail_i} = 3'h0;
        {on_backup_i, load_default_i, was_oe} = 3'h0;
        vdd_above_lockout_i = 1'b1;
        addr_i = '0;
        dq_i = '0;
        last = '0;
        error_cnt = 0;
        tests_run = 0;
        r = 8'($urandom(32'h1a1ef079));
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        rd(CA, 8'h24, 1'b1);
        wr(CA, r);
        wr(15'h7ff5, 8'hff);
        rd(15'h0123, 8'h00, 1'b0);
        rd(CA, r & 8'hfc, 1'b1);
        for (int i = 0; i < 3; i++) begin
            for (int e = 0; e < 2; e++) begin
                wr(CA, e ? 8'h80 >> i : 8'h00);
                fire(i);
                pinchk(e ? 2'b10 : 2'b00);
                rd(FA, 8'h80 >> i, 1'b1);
                pinchk(2'b00);
            end
        end
        wr(CA, 8'he0);
        fire(0);
        fire(1);
        wr(FA, 8'h00);
        rd(FA, 8'hc0, 1'b1);
        rd(FA, 8'h00, 1'b1);
        gate(1'b1, 1'b1, 8'h80, 0, 2'b00);
        gate(1'b1, 1'b0, 8'h40, 1, 2'b00);
        gate(1'b1, 1'b0, 8'h50, 1, 2'b10);
        gate(1'b0, 1'b0, 8'h30, 2, 2'b10);
        gate(1'b0, 1'b1, 8'h28, 2, 2'b11);
        gate(1'b0, 1'b0, 8'h28, 2, 2'b00);
        vdd_above_lockout_i <= 1'b1;
        wr(CA, 8'h00);
        load_default_i <= 1'b1;
        @(posedge clock_i);
        load_default_i <= 1'b0;
        rd(CA, 8'h24, 1'b1);
        fire(2);
        plen(14, 20);
        fire(2);
        repeat (8) @(posedge clock_i);
        fire(2);
        plen(14, 20);
        fire(2);
        rd(FA, 8'h20, 1'b1);
        pinchk(2'b00);
        stop_test();
    end
endmodule
